// ### pabl_pkg.sv
// pabl_pkg: constants, state type and lane helpers for the address/data byte-lane port.
// assumes one core clock; the host bus clock is sampled as an ordinary input.
// Functional notes
// - one address phase, then data phases
// - first cycle carries the byte address
// - later cycles carry data words only
// - little endian: msb on top lane
// - big endian: msb on bottom lane
// - initiator drives address, write data; releases reads
// - target receives address, write data; drives reads
// - address/data bus released when not involved
// - address/data change and sample on rising edges
// - first cycle command, later cycles byte enables
// - enable bit per lane, low means valid
// - drive enables as initiator, input as target
// - enable bus released when not involved
// - enables update and sample on rising edges
package pabl_pkg;
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int LANE_W = 8;
  localparam int CMD_WRITE_BIT = 0;
  localparam int SYNC_STAGES = 2;
  localparam int RX_DEPTH = 2;
  localparam logic [AD_W-1:0] AD_RST = 32'h0;
  localparam logic [CBE_W-1:0] CBE_RST = 4'hF;
  localparam logic OE_OFF = 1'b1;
  localparam logic OE_ON = 1'b0;

  typedef enum logic [1:0] {
    PABL_IDLE,
    PABL_I_ADDR,
    PABL_I_DATA,
    PABL_T_DATA
  } pabl_state_t;

  // lane swap for big-endian data; a no-op for little-endian
  function automatic logic [AD_W-1:0] pabl_swap_data(input logic [AD_W-1:0] d,
                                                     input logic big);
    logic [AD_W-1:0] r;
    r = d;
    if (big) begin
      for (int i = 0; i < CBE_W; i++) begin
        r[i*LANE_W +: LANE_W] = d[(CBE_W-1-i)*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction

  // byte enables follow their lanes through the swap
  function automatic logic [CBE_W-1:0] pabl_swap_be(input logic [CBE_W-1:0] b,
                                                    input logic big);
    logic [CBE_W-1:0] r;
    r = b;
    if (big) begin
      for (int i = 0; i < CBE_W; i++) begin
        r[i] = b[CBE_W-1-i];
      end
    end
    return r;
  endfunction
endpackage

// ### pabl_sync.sv
// pabl_sync: two-flop synchroniser for a bus of levels from outside the core domain.
// assumes multi-bit inputs are only read at points where they are settled.
`timescale 1ns/100ps
module pabl_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ### pabl_fifo.sv
// pabl_fifo: small flop buffer with valid/ready on both sides.
// assumes both sides on core_clk; full and empty are exact.
`timescale 1ns/100ps
module pabl_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// ### pabl_port.sv
// pabl_port: multiplexed address/data and command/byte-enable lanes of the host bus port.
// assumes framing, ready handshake and parity live in neighbouring logic on core_clk,
// which holds back the phase-done strobe while rx_stall is high.
`timescale 1ns/100ps
module pabl_port (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic host_bus_clock,
  input wire logic [pabl_pkg::AD_W-1:0] ad_in,
  output logic [pabl_pkg::AD_W-1:0] ad_out,
  output logic ad_oe_n,
  input wire logic [pabl_pkg::CBE_W-1:0] command_byte_enable_bus_in,
  output logic [pabl_pkg::CBE_W-1:0] command_byte_enable_bus_out,
  output logic command_byte_enable_bus_oe_n,
  input wire logic big_endian,
  input wire logic init_go,
  input wire logic init_write,
  input wire logic [pabl_pkg::AD_W-1:0] init_addr,
  input wire logic [pabl_pkg::CBE_W-1:0] init_cmd,
  input wire logic frame_start,
  input wire logic target_claim,
  input wire logic phase_done,
  input wire logic frame_end,
  input wire logic [pabl_pkg::AD_W-1:0] tx_data,
  input wire logic [pabl_pkg::CBE_W-1:0] tx_be_n,
  output logic tx_taken,
  output logic [pabl_pkg::AD_W-1:0] addr_seen,
  output logic [pabl_pkg::CBE_W-1:0] cmd_seen,
  output logic addr_valid,
  output logic [pabl_pkg::AD_W-1:0] rx_data,
  output logic [pabl_pkg::CBE_W-1:0] rx_be_n,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_stall
);
  localparam int BW = pabl_pkg::AD_W + pabl_pkg::CBE_W;

  pabl_pkg::pabl_state_t state;
  pabl_pkg::pabl_state_t next_state;

  logic clk_s;
  logic clk_d;
  logic [BW-1:0] pin_s;
  logic [BW-1:0] pin_d;
  logic write_q;
  logic claimed;
  logic push_valid;
  logic [BW-1:0] push_data;
  logic push_ready;
  logic [BW-1:0] pop_data;

  pabl_sync #(.W(1)) u_clk_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d(host_bus_clock),
    .q(clk_s)
  );

  pabl_sync #(.W(BW)) u_pin_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .d({command_byte_enable_bus_in, ad_in}),
    .q(pin_s)
  );

  // pin_d trails pin_s by one cycle so the sample is taken from just before the edge,
  // matching the extra flop in the rising-edge detector
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      clk_d <= 1'b0;
      pin_d <= '0;
    end else begin
      clk_d <= clk_s;
      pin_d <= pin_s;
    end
  end

  wire pclk_rise = clk_s && !clk_d;
  wire [pabl_pkg::AD_W-1:0] samp_ad = pin_d[pabl_pkg::AD_W-1:0];
  wire [pabl_pkg::CBE_W-1:0] samp_cbe = pin_d[BW-1:pabl_pkg::AD_W];
  wire samp_write = samp_cbe[pabl_pkg::CMD_WRITE_BIT];
  wire in_data_phase = (state == pabl_pkg::PABL_I_DATA) || (state == pabl_pkg::PABL_T_DATA);
  wire we_receive = (state == pabl_pkg::PABL_I_DATA) ? !write_q : (claimed && write_q);
  wire we_send = (state == pabl_pkg::PABL_I_DATA) ? write_q : (claimed && !write_q);
  wire phase_ends = pclk_rise && in_data_phase && phase_done;
  wire txn_ends = phase_ends && frame_end;
  wire [pabl_pkg::AD_W-1:0] tx_lanes = pabl_pkg::pabl_swap_data(tx_data, big_endian);
  wire [pabl_pkg::CBE_W-1:0] tx_lane_be = pabl_pkg::pabl_swap_be(tx_be_n, big_endian);
  wire [pabl_pkg::AD_W-1:0] rx_lanes = pabl_pkg::pabl_swap_data(samp_ad, big_endian);
  wire [pabl_pkg::CBE_W-1:0] rx_lane_be = pabl_pkg::pabl_swap_be(samp_cbe, big_endian);

  // phase sequencing: one address cycle, then data cycles until the last one completes
  always_comb begin
    next_state = state;
    unique case (state)
      pabl_pkg::PABL_IDLE: begin
        if (init_go) begin
          next_state = pabl_pkg::PABL_I_ADDR;
        end else if (frame_start) begin
          next_state = pabl_pkg::PABL_T_DATA;
        end
      end
      pabl_pkg::PABL_I_ADDR: begin
        next_state = pabl_pkg::PABL_I_DATA;
      end
      pabl_pkg::PABL_I_DATA, pabl_pkg::PABL_T_DATA: begin
        if (txn_ends) begin
          next_state = pabl_pkg::PABL_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= pabl_pkg::PABL_IDLE;
    end else if (pclk_rise) begin
      state <= next_state;
    end
  end

  // role and direction latch at the edge that enters a phase
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      write_q <= 1'b0;
      claimed <= 1'b0;
    end else if (pclk_rise) begin
      if (state == pabl_pkg::PABL_IDLE) begin
        write_q <= init_go ? init_write : samp_write;
        claimed <= 1'b0;
      end else if (state == pabl_pkg::PABL_T_DATA) begin
        claimed <= target_claim && !txn_ends;
      end
    end
  end

  // address/data drive: only at host bus clock rising edges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ad_out <= pabl_pkg::AD_RST;
      ad_oe_n <= pabl_pkg::OE_OFF;
    end else if (pclk_rise) begin
      if (state == pabl_pkg::PABL_IDLE && init_go) begin
        ad_out <= init_addr;
        ad_oe_n <= pabl_pkg::OE_ON;
      end else if (state == pabl_pkg::PABL_I_ADDR) begin
        ad_out <= tx_lanes;
        ad_oe_n <= write_q ? pabl_pkg::OE_ON : pabl_pkg::OE_OFF;
      end else if (state == pabl_pkg::PABL_T_DATA && !txn_ends) begin
        ad_out <= tx_lanes;
        ad_oe_n <= (target_claim && !write_q) ? pabl_pkg::OE_ON : pabl_pkg::OE_OFF;
      end else if (txn_ends || state == pabl_pkg::PABL_IDLE) begin
        ad_oe_n <= pabl_pkg::OE_OFF;
      end else if (phase_ends && we_send) begin
        ad_out <= tx_lanes;
      end
    end
  end

  // command/byte-enable drive: command first, byte enables afterwards
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      command_byte_enable_bus_out <= pabl_pkg::CBE_RST;
      command_byte_enable_bus_oe_n <= pabl_pkg::OE_OFF;
    end else if (pclk_rise) begin
      if (state == pabl_pkg::PABL_IDLE && init_go) begin
        command_byte_enable_bus_out <= init_cmd;
        command_byte_enable_bus_oe_n <= pabl_pkg::OE_ON;
      end else if (state == pabl_pkg::PABL_I_ADDR || (phase_ends && !txn_ends
                   && state == pabl_pkg::PABL_I_DATA)) begin
        command_byte_enable_bus_out <= tx_lane_be;
      end else if (txn_ends || state != pabl_pkg::PABL_I_DATA) begin
        command_byte_enable_bus_oe_n <= pabl_pkg::OE_OFF;
      end
    end
  end

  // target view of the address cycle, offered to the decoder on every frame_start that finds the port idle without init_go
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_seen <= pabl_pkg::AD_RST;
      cmd_seen <= pabl_pkg::CBE_RST;
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= 1'b0;
      if (pclk_rise && state == pabl_pkg::PABL_IDLE && !init_go && frame_start) begin
        addr_seen <= samp_ad;
        cmd_seen <= samp_cbe;
        addr_valid <= 1'b1;
      end
    end
  end

  // completed data phases: received words go to the buffer, sent words are acknowledged
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_taken <= 1'b0;
      push_valid <= 1'b0;
      push_data <= '0;
    end else begin
      tx_taken <= phase_ends && we_send;
      if (phase_ends && we_receive) begin
        push_valid <= 1'b1;
        push_data <= {rx_lane_be, rx_lanes};
      end else if (push_ready) begin
        push_valid <= 1'b0;
      end
    end
  end

  // the neighbour must not complete a receive phase while stalled, or a word is lost
  assign rx_stall = !push_ready || push_valid;

  pabl_fifo #(.W(BW), .DEPTH(pabl_pkg::RX_DEPTH)) u_rx_buf (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(pop_data)
  );

  assign rx_data = pop_data[pabl_pkg::AD_W-1:0];
  assign rx_be_n = pop_data[BW-1:pabl_pkg::AD_W];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_init_start;
    pclk_rise && state == pabl_pkg::PABL_IDLE && init_go;
  endsequence

  sequence s_addr_edge;
    pclk_rise && state == pabl_pkg::PABL_I_ADDR;
  endsequence

  AST_AD_EDGE_ONLY: assert property ($changed(ad_out) || $changed(ad_oe_n) |-> $past(pclk_rise))
    else $error("address/data bus moved off a host clock edge");
  AST_CBE_EDGE_ONLY: assert property ($changed(command_byte_enable_bus_out) |-> $past(pclk_rise))
    else $error("enable bus moved off a host clock edge");
  AST_IDLE_RELEASED: assert property (state == pabl_pkg::PABL_IDLE && $past(state) == pabl_pkg::PABL_IDLE |-> ad_oe_n && command_byte_enable_bus_oe_n)
    else $error("bus driven while not involved");
  AST_ADDR_PHASE: assert property (s_init_start |=> state == pabl_pkg::PABL_I_ADDR && !ad_oe_n && ad_out == $past(init_addr) && command_byte_enable_bus_out == $past(init_cmd))
    else $error("address phase not driven with unswapped address and command");
  AST_ADDR_THEN_DATA: assert property (s_addr_edge |=> state == pabl_pkg::PABL_I_DATA && command_byte_enable_bus_out == $past(tx_lane_be))
    else $error("address phase not followed by a data phase");
  AST_INIT_WRITE_LANES: assert property (s_addr_edge ##0 write_q |=> !ad_oe_n && ad_out == pabl_pkg::pabl_swap_data($past(tx_data), $past(big_endian)))
    else $error("initiator write data not on the selected lanes");
  AST_INIT_READ_RELEASE: assert property (s_addr_edge ##0 !write_q |=> ad_oe_n)
    else $error("initiator read did not release the bus");
  AST_TARGET_CBE_INPUT: assert property (state == pabl_pkg::PABL_T_DATA |-> command_byte_enable_bus_oe_n)
    else $error("enable bus driven while target");
  AST_TARGET_WRITE_INPUT: assert property (state == pabl_pkg::PABL_T_DATA && write_q |-> ad_oe_n)
    else $error("target drove the bus during a write");
  AST_RX_PUSH: assert property (phase_ends && we_receive |=> push_valid && push_data[pabl_pkg::AD_W-1:0] == pabl_pkg::pabl_swap_data($past(samp_ad), $past(big_endian)))
    else $error("received word not captured with lane order");
endmodule

// ### pabl_agent.sv
// pabl_agent: far-side bus agent; makes the host bus clock and resolves the shared pins.
// assumes the bench sets the agent's own drive values well clear of host clock rises.
`timescale 1ns/100ps
module pabl_agent (
  output logic host_bus_clock,
  input wire logic [31:0] ad_out,
  input wire logic ad_oe_n,
  input wire logic [3:0] cbe_out,
  input wire logic cbe_oe_n,
  input wire logic ag_ad_en,
  input wire logic [31:0] ag_ad,
  input wire logic ag_cbe_en,
  input wire logic [3:0] ag_cbe,
  output logic [31:0] ad_pin,
  output logic [3:0] cbe_pin
);
  logic [31:0] ad_last = '0;
  logic [3:0] cbe_last = '0;
  // free-running host clock, offset so each of its edges falls 13 ns before a core clock rise
  initial begin
    host_bus_clock = 1'b0;
    #37;
    forever #400 host_bus_clock = ~host_bus_clock;
  end
  // a released bus shows the inverse of its last level, so stale data never passes
  always @(posedge host_bus_clock) begin
    ad_last <= ad_pin;
    cbe_last <= cbe_pin;
  end
  // two drivers at once give an unknown level that the bench will see
  assign ad_pin = !ad_oe_n ? (ag_ad_en ? 'x : ad_out) : (ag_ad_en ? ag_ad : ~ad_last);
  assign cbe_pin = !cbe_oe_n ? (ag_cbe_en ? 'x : cbe_out) : (ag_cbe_en ? ag_cbe : ~cbe_last);
endmodule

// ### tb.sv
// tb: self-checking bench for the byte-lane port, with a queue model of the receive path.
// assumes pabl_agent makes the host bus clock and resolves the shared pins.
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hclk, ad_oe_n, cbe_oe_n, tx_taken, addr_valid, rx_valid, rx_stall;
  logic big_endian, init_go, init_write, frame_start, target_claim, phase_done, frame_end;
  logic rx_ready, ag_ad_en, ag_cbe_en;
  logic rx_on = 1'b1;
  logic [31:0] ad_pin, ad_out, init_addr, tx_data, addr_seen, rx_data, ag_ad, rr;
  logic [3:0] cbe_pin, cbe_out, init_cmd, tx_be_n, cmd_seen, rx_be_n, ag_cbe;
  logic [31:0] seed = 32'h0000004D;
  logic [35:0] exp_q[$];
  int n_mismatch = 0;
  int checks = 0;
  int n_tx = 0;
  int n_addr = 0;
  int stl = 0;

  always #50 core_clk = ~core_clk;

  pabl_port i_dut (
    .core_clk(core_clk), .rstn(rstn), .host_bus_clock(hclk), .ad_in(ad_pin),
    .ad_out(ad_out), .ad_oe_n(ad_oe_n), .command_byte_enable_bus_in(cbe_pin),
    .command_byte_enable_bus_out(cbe_out), .command_byte_enable_bus_oe_n(cbe_oe_n),
    .big_endian(big_endian), .init_go(init_go), .init_write(init_write),
    .init_addr(init_addr), .init_cmd(init_cmd), .frame_start(frame_start),
    .target_claim(target_claim), .phase_done(phase_done), .frame_end(frame_end),
    .tx_data(tx_data), .tx_be_n(tx_be_n), .tx_taken(tx_taken), .addr_seen(addr_seen),
    .cmd_seen(cmd_seen), .addr_valid(addr_valid), .rx_data(rx_data), .rx_be_n(rx_be_n),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_stall(rx_stall)
  );

  pabl_agent i_agent (
    .host_bus_clock(hclk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .cbe_out(cbe_out),
    .cbe_oe_n(cbe_oe_n), .ag_ad_en(ag_ad_en), .ag_ad(ag_ad), .ag_cbe_en(ag_cbe_en),
    .ag_cbe(ag_cbe), .ad_pin(ad_pin), .cbe_pin(cbe_pin)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // {enables, data}: big endian mirrors the byte lanes and their enable bits together
  function automatic logic [35:0] sw(input logic [35:0] w, input logic big);
    if (!big) return w;
    return {w[32], w[33], w[34], w[35], w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  task automatic chk(input logic [37:0] s, input logic [37:0] e, input string what);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, s, e);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // mid-way between host rises: outputs have settled and inputs have time to sync
  task automatic step();
    @(negedge hclk);
    repeat (2) @(posedge core_clk);
  endtask

  // design outputs are looked at mid-cycle, where they have settled; a pop happens
  // at the next rising edge when both valid and ready stand here
  always @(negedge core_clk) begin
    if (rstn && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (exp_q.size() == 0) chk(38'h1, 38'h0, "word not expected");
      else chk({2'b00, rx_be_n, rx_data}, {2'b00, exp_q.pop_front()}, "rx word");
    end
    if (tx_taken === 1'b1) n_tx++;
    if (addr_valid === 1'b1) n_addr++;
  end

  always @(posedge core_clk) begin
    rr = rnd();
    rx_ready <= rx_on & rr[0];
  end

  task automatic xact(input logic ini, input logic wr, input logic claim, input int n);
    logic [31:0] a, d;
    logic [3:0] c, b, mc;
    logic [35:0] x;
    logic [37:0] s, e;
    logic drv, recv;
    int nt, na;
    a = rnd();
    c = {a[7:5], wr};
    drv = ini ? wr : (!wr && claim);
    recv = ini ? !wr : wr;
    mc = {4{ini}};
    nt = n_tx;
    na = n_addr;
    step();
    init_go <= ini;
    init_write <= wr;
    init_addr <= a;
    init_cmd <= c;
    frame_start <= !ini;
    ag_ad_en <= !ini;
    ag_cbe_en <= !ini;
    ag_ad <= a;
    ag_cbe <= c;
    step();
    s = {cbe_oe_n, ad_oe_n, ini ? {cbe_out, ad_out} : {cmd_seen, addr_seen}};
    chk(s, {!ini, !ini, c, a}, "address phase");
    init_go <= 1'b0;
    frame_start <= 1'b0;
    target_claim <= claim;
    ag_ad_en <= recv;
    d = rnd();
    b = d[19:16] ^ d[3:0];
    tx_data <= d;
    tx_be_n <= b;
    for (int i = 0; i < n; i++) begin
      x = sw({b, d}, big_endian);
      // the far side holds word i until the completing rise has sampled it
      ag_ad <= d;
      ag_cbe <= b;
      step();
      s = {cbe_oe_n, ad_oe_n, cbe_out & mc, ad_out & {32{drv}}};
      e = {!ini, !drv, x[35:32] & mc, x[31:0] & {32{drv}}};
      chk(s, e, "data phase");
      // wait states while the buffer is full; the consumer wakes after a few
      for (int w = 0; rx_stall !== 1'b0 && w < 40; w++) begin
        stl++;
        if (w == 3) rx_on = 1'b1;
        step();
      end
      if (recv) exp_q.push_back(ini ? {b, x[31:0]} : x);
      phase_done <= 1'b1;
      frame_end <= (i == n - 1);
      // the sending side presents the next word before the phase completes
      d = rnd();
      b = d[19:16] ^ d[3:0];
      tx_data <= d;
      tx_be_n <= b;
      step();
      phase_done <= 1'b0;
    end
    frame_end <= 1'b0;
    target_claim <= 1'b0;
    ag_ad_en <= 1'b0;
    ag_cbe_en <= 1'b0;
    chk({36'h0, cbe_oe_n, ad_oe_n}, 38'h3, "released at end");
    chk(38'(n_tx - nt), drv ? 38'(n) : 38'h0, "sent phases");
    if (!ini) chk(38'(n_addr - na), 38'h1, "address seen");
  endtask

  initial begin
    {big_endian, init_go, init_write, frame_start, target_claim, phase_done, frame_end} = '0;
    {rx_ready, ag_ad_en, ag_cbe_en} = '0;
    {init_addr, tx_data, ag_ad} = '0;
    {init_cmd, tx_be_n, ag_cbe} = '0;
    repeat (3) @(posedge core_clk);
    chk({cbe_oe_n, ad_oe_n, cbe_out, ad_out}, {2'b11, 4'hF, 32'h0}, "reset pins");
    chk({34'h0, rx_valid, rx_stall, addr_valid, tx_taken}, 38'h0, "reset flags");
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) step();
    for (int k = 0; k < 4; k++) begin
      big_endian <= k[0];
      xact(1'b1, 1'b1, 1'b0, k + 1);
      xact(1'b1, 1'b0, 1'b0, 2);
      xact(1'b0, 1'b1, 1'b1, 2);
      xact(1'b0, 1'b0, 1'b1, k + 1);
      xact(1'b0, 1'b0, 1'b0, 1);
    end
    rx_on = 1'b0;
    xact(1'b0, 1'b1, 1'b1, 3);
    chk(38'(stl > 0), 38'h1, "receiver stall seen");
    repeat (20) @(posedge core_clk);
    chk({37'(exp_q.size()), rx_valid}, 38'h0, "buffer drained");
    stop_test();
  end

  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
endmodule
